// >>> logic/dsp_consts.svh
// Constants for the accumulator datapath: offsets, bit positions, resets
// ----------------------------------------------------------------------
// Operation
// - 73-bit adder uses selected accumulator both ends
// - Subtract and negate ops invert one operand
// - Guard overflow flags rewritten every pass
// - Summary bits OR flags; clearing clears both
// - Clamped flags sticky, software may set
// - Without saturation clamped flag marks catastrophe
// - Guard overflow traps only when enabled
// - Catastrophic overflow traps when enabled, unsaturated
// - Trap occurrences recorded in error bits
// - Wide mode clamps to 9.63 limits
// - Narrow mode clamps beyond bit 63
// - Clamp disabled lets accumulator wrap
// - Only DSP accumulator writes update flags
// - Store clamp enable resets on, source untouched
// - Store: shift, optional round, then saturate
// - Write-back of rounded other accumulator to register
// - Indirect write-back then pointer steps 2/4
// - Style bit picks rounding; conventional adds bit31 in long mode, bit47 in word mode
// - Convergent rounding ties check upper lsb
// - Write-back always rounded and saturated
// - Signed barrel shift, right positive, left negative
// - Shift beyond 32 traps, target unwritten
// - Two split 72-bit accumulators, not mapped
// - Fractional mode doubles product, lsb cleared
// ----------------------------------------------------------------------
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH
`define OFS_CORE_CONFIG  3'h0
`define OFS_CPU_FLAGS    3'h1
`define OFS_TRAP_CONTROL 3'h2
`define OFS_WB_POINTER   3'h3
`define OFS_STACK_PTR    3'h4
`define CFG_FRAC         0
`define CFG_ROUND_STYLE  1
`define CFG_CLAMP_WIDTH  4
`define CFG_STORE_CLAMP  5
`define CFG_CLAMP_EN_B   6
`define CFG_CLAMP_EN_A   7
`define CFG_RESET        32'h0000_0021
`define FL_GUARD_A       15
`define FL_GUARD_B       14
`define FL_CLAMP_A       13
`define FL_CLAMP_B       12
`define FL_EITHER_GUARD  11
`define FL_EITHER_CLAMP  10
`define TC_EN_GUARD_A    21
`define TC_EN_GUARD_B    20
`define TC_EN_CATAS      19
`define TC_ERR_GUARD_A   5
`define TC_ERR_GUARD_B   4
`define TC_ERR_CATAS_A   3
`define TC_ERR_CATAS_B   2
`define TC_ERR_SHIFT     1
`define SHIFT_LIMIT      7'sd32
`define MAX_963          72'h7F_FFFF_FFFF_FFFF_FFFF
`define MIN_963          72'h80_0000_0000_0000_0000
`define MAX_163          72'h00_7FFF_FFFF_FFFF_FFFF
`define MIN_163          72'hFF_8000_0000_0000_0000
`endif

// >>> logic/dsp_pkg.sv
// Types shared by the accumulator datapath files
package dsp_pkg;
  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_MAC       = 4'h1,
    OP_MSC       = 4'h2,
    OP_MPY       = 4'h3,
    OP_MULT_NEGATE_OP      = 4'h4,
    OP_ADD_ACC   = 4'h5,
    OP_LOAD_ACC  = 4'h6,
    OP_SHIFT_ACC = 4'h7,
    OP_STORE     = 4'h8,
    OP_STORE_RND = 4'h9,
    OP_INT_WRITE = 4'hA
  } op_e;
  typedef struct packed {
    op_e               op;
    logic              acc_b;
    logic              word;
    logic [63:0]       prod;
    logic              prod_unsigned;
    logic [71:0]       operand;
    logic signed [6:0] shamt;
    logic              wb_en;
    logic              wb_indirect;
    logic              wb_use_sp;
    logic [2:0]        wb_reg;
  } cmd_s;
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [31:0] addr;
    logic [2:0]  reg_idx;
  } wr_s;
endpackage : dsp_pkg

// >>> logic/barrel_shift72.sv
// Signed-amount 72-bit barrel shifter
`timescale 1ns/10ps
module barrel_shift72 (
  input  wire logic [71:0]       din,
  input  wire logic signed [6:0] amount,
  output logic [71:0]            dout72,
  output logic [31:0]            dout32
);
  // Positive shifts right arithmetically, negative shifts left
  wire logic [6:0]  mag   = amount[6] ? 7'(-amount) : amount;
  wire logic [71:0] right = 72'($signed(din) >>> mag);
  wire logic [71:0] left  = din << mag;
  assign dout72 = amount[6] ? left : right;
  assign dout32 = dout72[31:0];
endmodule : barrel_shift72

// >>> logic/acc_round.sv
// Conventional or convergent rounding of an accumulator value
`timescale 1ns/10ps
module acc_round (
  input  wire logic [71:0] din,
  input  wire logic        word,
  input  wire logic        convergent,
  output logic [71:0]      dout
);
  // Long mode rounds at bit 31; word mode one word higher
  wire logic half = word ? din[47] : din[31];
  wire logic tie  = word ? (din[47:0] == 48'h8000_0000_0000)
                         : (din[31:0] == 32'h8000_0000);
  wire logic lsb  = word ? din[48] : din[32];
  // Exact ties round to even only in convergent style
  wire logic inc  = half & (~convergent | ~tie | lsb);
  wire logic [71:0] step = word ? 72'h00_0001_0000_0000_0000
                                : 72'h00_0000_0001_0000_0000;
  assign dout = din + (inc ? step : 72'h0);
endmodule : acc_round

// >>> logic/dsp_accum.sv
// Accumulator adder, saturation, store, write-back and trap logic
`timescale 1ns/10ps
`include "dsp_consts.svh"
module dsp_accum (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic [2:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire dsp_pkg::cmd_s cmd,
  output dsp_pkg::wr_s       store_out,
  output dsp_pkg::wr_s       wb_reg_out,
  output dsp_pkg::wr_s       wb_mem_out,
  output logic               trap_req
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [71:0] acc_a_r, acc_b_r;  // Split views are [31:0] [63:32] [71:64]
  logic [31:0] cfg_r, tc_r, wbp_r, sp_r, rdata_r;
  logic [5:0]  fl_r;              // Guard A,B, clamped A,B
  logic        wait_r, trap_r;
  dsp_pkg::wr_s st_r, wr_r, wm_r;

  // Saturate a rounded value to 1.15 or 1.31 when enabled
  function automatic logic [31:0] sat_out(input logic [71:0] v,
                                          input logic word,
                                          input logic en);
    logic ovf;
    ovf = en & ~((&v[71:63]) | ~(|v[71:63]));
    if (ovf)
      sat_out = word ? (v[71] ? 32'h0000_8000 : 32'h0000_7FFF)
                     : (v[71] ? 32'h8000_0000 : 32'h7FFF_FFFF);
    else
      sat_out = word ? {16'h0000, v[63:48]} : v[63:32];
  endfunction : sat_out

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  wire dsp_pkg::op_e op = cmd.op;
  wire logic is_mul  = (op == dsp_pkg::OP_MAC) | (op == dsp_pkg::OP_MSC) |
                       (op == dsp_pkg::OP_MPY) | (op == dsp_pkg::OP_MULT_NEGATE_OP);
  wire logic is_acc  = (op == dsp_pkg::OP_MAC) | (op == dsp_pkg::OP_MSC) |
                       (op == dsp_pkg::OP_ADD_ACC);
  wire logic is_ld   = (op == dsp_pkg::OP_ADD_ACC) |
                       (op == dsp_pkg::OP_LOAD_ACC);
  wire logic is_neg  = (op == dsp_pkg::OP_MSC) | (op == dsp_pkg::OP_MULT_NEGATE_OP);
  wire logic is_sft  = (op == dsp_pkg::OP_SHIFT_ACC);
  wire logic is_st   = (op == dsp_pkg::OP_STORE) |
                       (op == dsp_pkg::OP_STORE_RND);
  wire logic is_int  = (op == dsp_pkg::OP_INT_WRITE);
  wire logic sft_bad = is_sft & ((cmd.shamt > `SHIFT_LIMIT) |
                                 (cmd.shamt < -`SHIFT_LIMIT));
  // Only DSP accumulator writes go through the flag logic
  wire logic dsp_wr  = is_mul | is_ld | (is_sft & ~sft_bad);
  wire logic [71:0] tgt   = cmd.acc_b ? acc_b_r : acc_a_r;
  wire logic [71:0] other = cmd.acc_b ? acc_a_r : acc_b_r;

  // ------------------------------------------------------------
  // Shifters and rounders
  // ------------------------------------------------------------
  logic [71:0] sh_ld, sh_tgt, rnd_st, rnd_wb;
  barrel_shift72 u_sh_ld (
    .din    (cmd.operand),
    .amount (cmd.shamt),
    .dout72 (sh_ld),
    .dout32 ()
  );
  barrel_shift72 u_sh_tgt (
    .din    (tgt),
    .amount (cmd.shamt),
    .dout72 (sh_tgt),
    .dout32 ()
  );
  acc_round u_rnd_st (
    .din        (sh_tgt),
    .word       (cmd.word),
    .convergent (cfg_r[`CFG_ROUND_STYLE]),
    .dout       (rnd_st)
  );
  acc_round u_rnd_wb (
    .din        (other),
    .word       (cmd.word),
    .convergent (cfg_r[`CFG_ROUND_STYLE]),
    .dout       (rnd_wb)
  );

  // ------------------------------------------------------------
  // Adder operands and 73-bit sum
  // ------------------------------------------------------------
  // Product is sign or zero extended, doubled in fractional mode
  wire logic [71:0] prod_x = {{8{cmd.prod[63] & ~cmd.prod_unsigned}},
                              cmd.prod};
  wire logic [71:0] prod_f = cfg_r[`CFG_FRAC] ? {prod_x[70:0], 1'b0}
                                              : prod_x;
  wire logic [71:0] opb  = is_mul ? prod_f : (is_sft ? sh_tgt : sh_ld);
  wire logic [71:0] opa  = (is_acc) ? tgt : 72'h0;
  // Negation happens in the adder; stored sources stay as they are
  wire logic [72:0] opbn = is_neg ? 73'(-{opb[71], opb})
                                  : {opb[71], opb};
  wire logic [72:0] sum  = {opa[71], opa} + opbn;
  wire logic [71:0] res  = sum[71:0];

  // ------------------------------------------------------------
  // Overflow and saturation
  // ------------------------------------------------------------
  wire logic clamp_en = cmd.acc_b ? cfg_r[`CFG_CLAMP_EN_B]
                                  : cfg_r[`CFG_CLAMP_EN_A];
  wire logic wide     = cfg_r[`CFG_CLAMP_WIDTH];
  // Guard bits in use when bits 71..63 disagree
  wire logic guard_ov = ~((&res[71:63]) | ~(|res[71:63]));
  wire logic ov71     = sum[72] ^ sum[71];
  wire logic ov63     = ov71 | guard_ov;
  wire logic sat_hit  = clamp_en & (wide ? ov71 : ov63);
  wire logic catas    = ~clamp_en & ov71;
  wire logic [71:0] sat_val =
    wide ? (sum[72] ? `MIN_963 : `MAX_963)
         : (sum[72] ? `MIN_163 : `MAX_163);
  // With clamp off the sum wraps through bit 71
  wire logic [71:0] acc_nxt = sat_hit ? sat_val : res;
  wire logic g_ev   = dsp_wr & guard_ov;
  wire logic c_ev   = dsp_wr & (sat_hit | catas);
  wire logic g_a    = g_ev & ~cmd.acc_b;
  wire logic g_b    = g_ev & cmd.acc_b;
  wire logic c_a    = c_ev & ~cmd.acc_b;
  wire logic c_b    = c_ev & cmd.acc_b;
  wire logic k_a    = dsp_wr & catas & ~cmd.acc_b;
  wire logic k_b    = dsp_wr & catas & cmd.acc_b;
  wire logic trap_g = (g_a & tc_r[`TC_EN_GUARD_A]) |
                      (g_b & tc_r[`TC_EN_GUARD_B]);
  wire logic trap_k = (k_a | k_b) & tc_r[`TC_EN_CATAS];

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire logic rd_go = avs_read & wait_r;
  wire logic wr_go = avs_write & ~wait_r;
  wire logic w_cfg = wr_go & (avs_address == `OFS_CORE_CONFIG);
  wire logic w_fl  = wr_go & (avs_address == `OFS_CPU_FLAGS);
  wire logic w_tc  = wr_go & (avs_address == `OFS_TRAP_CONTROL);
  wire logic w_wbp = wr_go & (avs_address == `OFS_WB_POINTER);
  wire logic w_sp  = wr_go & (avs_address == `OFS_STACK_PTR);
  wire logic [31:0] fl_view = {16'h0, fl_r[5:2], |fl_r[5:4], |fl_r[3:2],
                               10'h0};
  wire logic [31:0] rd_mux =
    (avs_address == `OFS_CORE_CONFIG)  ? cfg_r :
    (avs_address == `OFS_CPU_FLAGS)    ? fl_view :
    (avs_address == `OFS_TRAP_CONTROL) ? tc_r :
    (avs_address == `OFS_WB_POINTER)   ? wbp_r :
    (avs_address == `OFS_STACK_PTR)    ? sp_r : 32'h0;

  // Software image of the flags; summary zero clears both halves
  wire logic [31:0] wd = avs_writedata;
  wire logic [5:0]  fl_sw = {wd[`FL_GUARD_A]  & wd[`FL_EITHER_GUARD],
                             wd[`FL_GUARD_B]  & wd[`FL_EITHER_GUARD],
                             wd[`FL_CLAMP_A]  & wd[`FL_EITHER_CLAMP],
                             wd[`FL_CLAMP_B]  & wd[`FL_EITHER_CLAMP],
                             2'h0};
  wire logic [5:0] fl_base = w_fl ? fl_sw : fl_r;
  // Guards are rewritten per pass; clamped flags set and stick
  wire logic [5:0] fl_nxt = {dsp_wr ? {g_a, g_b} : fl_base[5:4],
                             fl_base[3:2] | {c_a, c_b},
                             2'h0};
  wire logic [4:0] err_set = {g_a & tc_r[`TC_EN_GUARD_A],
                              g_b & tc_r[`TC_EN_GUARD_B],
                              k_a & tc_r[`TC_EN_CATAS],
                              k_b & tc_r[`TC_EN_CATAS], sft_bad};
  wire logic [4:0] err_old = w_tc ? wd[5:1] : tc_r[5:1];
  // Hardware set wins over a software clear in the same cycle
  wire logic [31:0] tc_nxt = {10'h0, (w_tc ? wd[21:19] : tc_r[21:19]),
                              13'h0, err_old | err_set, 1'b0};

  // ------------------------------------------------------------
  // Store and write-back data
  // ------------------------------------------------------------
  wire logic [71:0] st_src = (op == dsp_pkg::OP_STORE_RND) ? rnd_st
                                                           : sh_tgt;
  wire logic [31:0] st_dat = sat_out(st_src, cmd.word,
                                     cfg_r[`CFG_STORE_CLAMP]);
  // Write-back is always rounded and always saturated
  wire logic [31:0] wb_dat = sat_out(rnd_wb, cmd.word, 1'b1);
  wire logic wb_go  = cmd.wb_en & ((op == dsp_pkg::OP_MAC) |
                                   (op == dsp_pkg::OP_MSC));
  wire logic wb_dir = wb_go & ~cmd.wb_indirect;
  wire logic wb_ind = wb_go & cmd.wb_indirect;
  wire logic [31:0] ptr_step = cmd.word ? 32'h2 : 32'h4;
  wire logic [31:0] wb_addr  = cmd.wb_use_sp ? sp_r : wbp_r;
  wire logic dir_wbp = wb_dir & (cmd.wb_reg == 3'h4);
  wire logic [31:0] wbp_nxt =
    (wb_ind & ~cmd.wb_use_sp) ? wbp_r + ptr_step :
    dir_wbp ? wb_dat : (w_wbp ? wd : wbp_r);
  wire logic [31:0] sp_nxt =
    (wb_ind & cmd.wb_use_sp) ? sp_r + ptr_step : (w_sp ? wd : sp_r);

  // ------------------------------------------------------------
  // Accumulator commit; integer writes bypass the flag logic
  // ------------------------------------------------------------
  wire logic wr_a = (dsp_wr | is_int) & ~cmd.acc_b;
  wire logic wr_b = (dsp_wr | is_int) & cmd.acc_b;
  wire logic [71:0] acc_val = is_int ? cmd.operand : acc_nxt;

  // Accumulators and pointers; stores never touch them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_a_r <= 72'h0;
      acc_b_r <= 72'h0;
      wbp_r   <= 32'h0;
      sp_r    <= 32'h0;
    end else begin
      if (wr_a) acc_a_r <= acc_val;
      if (wr_b) acc_b_r <= acc_val;
      wbp_r <= wbp_nxt;
      sp_r  <= sp_nxt;
    end
  end

  // Flags, error record and trap commit with the result
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fl_r   <= 6'h0;
      tc_r   <= 32'h0;
      trap_r <= 1'b0;
    end else begin
      fl_r   <= fl_nxt;
      tc_r   <= tc_nxt;
      trap_r <= trap_g | trap_k | sft_bad;
    end
  end

  // Configuration; store clamp enabled out of reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) cfg_r <= `CFG_RESET;
    else if (w_cfg) cfg_r <= wd & 32'h0000_00F3;
  end

  // Bus slave answers one cycle after the request is seen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r  <= ~((avs_read | avs_write) & wait_r);
      if (rd_go) rdata_r <= rd_mux;
    end
  end

  // Result strobes last one cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      wr_r <= '0;
      wm_r <= '0;
    end else begin
      st_r <= '{is_st, st_dat, 32'h0, 3'h0};
      wr_r <= '{wb_dir, wb_dat, 32'h0, cmd.wb_reg};
      wm_r <= '{wb_ind, wb_dat, wb_addr, 3'h0};
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign store_out       = st_r;
  assign wb_reg_out      = wr_r;
  assign wb_mem_out      = wm_r;
  assign trap_req        = trap_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_req;
    (avs_read | avs_write) & avs_waitrequest;
  endsequence
  sequence s_ack;
    ~avs_waitrequest;
  endsequence
  property p_bus_ack;
    @(posedge core_clk) disable iff (!rst_n) s_req |=> s_ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("bus did not answer in one cycle");
  property p_guard_a;
    @(posedge core_clk) disable iff (!rst_n)
      (dsp_wr & ~cmd.acc_b & ~w_fl) |=> (fl_r[5] == $past(guard_ov));
  endproperty
  a_guard_a: assert property (p_guard_a)
    else $error("guard flag A not rewritten");
  property p_clamp_sticky;
    @(posedge core_clk) disable iff (!rst_n)
      (fl_r[3] & ~w_fl) |=> fl_r[3];
  endproperty
  a_clamp_sticky: assert property (p_clamp_sticky)
    else $error("clamped flag A dropped without software");
  property p_summary;
    @(posedge core_clk) disable iff (!rst_n)
      (rd_go & (avs_address == `OFS_CPU_FLAGS)) |=>
        (avs_readdata[15:12] == $past(fl_r[5:2])) &
        (avs_readdata[11] == |$past(fl_r[5:4])) &
        (avs_readdata[10] == |$past(fl_r[3:2]));
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bits wrong");
  property p_shift_trap;
    @(posedge core_clk) disable iff (!rst_n)
      sft_bad |=> trap_req & tc_r[1] & $stable(acc_a_r) & $stable(acc_b_r);
  endproperty
  a_shift_trap: assert property (p_shift_trap)
    else $error("bad shift not trapped or accumulator written");
  property p_sat_a;
    @(posedge core_clk) disable iff (!rst_n)
      (dsp_wr & ~cmd.acc_b & cfg_r[7] & cfg_r[4] & ov71) |=>
        (acc_a_r == `MAX_963) | (acc_a_r == `MIN_963);
  endproperty
  a_sat_a: assert property (p_sat_a)
    else $error("wide saturation value wrong");
  property p_store_keep;
    @(posedge core_clk) disable iff (!rst_n)
      is_st |=> $stable(acc_a_r) & $stable(acc_b_r) & store_out.valid;
  endproperty
  a_store_keep: assert property (p_store_keep)
    else $error("store altered an accumulator");
  property p_int_noflag;
    @(posedge core_clk) disable iff (!rst_n)
      (is_int & ~w_fl) |=> $stable(fl_r);
  endproperty
  a_int_noflag: assert property (p_int_noflag)
    else $error("integer write changed accumulator flags");
  property p_ptr_step;
    @(posedge core_clk) disable iff (!rst_n)
      (wb_ind & ~cmd.wb_use_sp & cmd.word) |=> wbp_r == $past(wbp_r) + 32'h2;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer did not step by two");
endmodule : dsp_accum

// >>> verification/data_mem_model.sv
// Data memory stand-in that records stores and indirect write-backs
`timescale 1ns/10ps
module data_mem_model (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire dsp_pkg::wr_s store_out,
  input  wire dsp_pkg::wr_s wb_mem_out,
  output logic [31:0]       last_addr,
  output logic [31:0]       last_data,
  output logic [7:0]        writes
);
  // Keep the newest write; a strobe held too long shows as extra writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      writes <= 8'h00;
    end else if (wb_mem_out.valid) begin
      writes    <= writes + 8'h01;
      last_addr <= wb_mem_out.addr;
      last_data <= wb_mem_out.data;
    end else if (store_out.valid) begin
      writes    <= writes + 8'h01;
      last_data <= store_out.data;
    end
  end
endmodule : data_mem_model

// >>> verification/dsp_accumulator_datapath_tb_top.sv
// Self-checking bench for the accumulator datapath
`timescale 1ns/10ps
`include "dsp_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module dsp_accumulator_datapath_tb_top;
  localparam dsp_pkg::op_e op_ld  = dsp_pkg::OP_LOAD_ACC;
  localparam dsp_pkg::op_e op_add = dsp_pkg::OP_ADD_ACC;
  localparam dsp_pkg::op_e op_acc = dsp_pkg::OP_MAC;
  logic          core_clk, rst_n, avs_read, avs_write, trap_req;
  logic [2:0]    avs_address;
  logic [31:0]   avs_writedata, avs_readdata, rd, last_addr, last_data;
  logic          avs_waitrequest;
  logic [7:0]    writes, w0;
  dsp_pkg::cmd_s c, cmd;
  dsp_pkg::wr_s  store_out, wb_reg_out, wb_mem_out;
  int            errors, checks_done, cyc;

  // Free-running core clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  dsp_accum i_dsp_accum (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmd(cmd), .store_out(store_out),
    .wb_reg_out(wb_reg_out), .wb_mem_out(wb_mem_out), .trap_req(trap_req));
  data_mem_model i_data_mem_model (.core_clk(core_clk), .rst_n(rst_n),
    .store_out(store_out), .wb_mem_out(wb_mem_out),
    .last_addr(last_addr), .last_data(last_data), .writes(writes));

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end

  // Avalon cycle: hold everything until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // One command for one cycle; results are looked at in the next cycle
  task automatic op(input dsp_pkg::op_e o, input logic b,
                    input logic [71:0] v);
    c.op      = o;
    c.acc_b   = b;
    c.operand = v;
    c.prod    = v[63:0];
    @(posedge core_clk);
    cmd <= c;
    @(posedge core_clk);
    cmd <= '0;
    #1;
  endtask : op

  task automatic st(input logic b, input logic signed [6:0] s, input logic r,
                    input logic [31:0] e);
    c.shamt = s;
    if (r) begin
      op(dsp_pkg::OP_STORE_RND, b, 72'h0);
    end else begin
      op(dsp_pkg::OP_STORE, b, 72'h0);
    end
    c.shamt = 7'sd0;
    `CHK(store_out.data, e)
  endtask : st

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset;
    bus(1'b0, `OFS_CORE_CONFIG, 32'h0);
    `CHK(rd, `CFG_RESET)
    bus(1'b1, 3'h6, 32'hFFFF_FFFF);
    bus(1'b0, 3'h6, 32'h0);
    `CHK(rd, 32'h0)
    $display("test reset done");
  endtask : t_reset

  // Integer mode first so that operand and result stay equal in size
  task automatic t_mult;
    bus(1'b1, `OFS_CORE_CONFIG, 32'h20);
    c.prod_unsigned = 1'b1;
    op(dsp_pkg::OP_MPY, 1'b0, 72'hFFFF_FFFF_FFFF_FFFF);
    bus(1'b0, `OFS_CPU_FLAGS, 32'h0);
    `CHK(rd[15], 1'b1)
    c.prod_unsigned = 1'b0;
    op(dsp_pkg::OP_MPY, 1'b0, 72'hFFFF_FFFF_FFFF_FFFF);
    bus(1'b0, `OFS_CPU_FLAGS, 32'h0);
    `CHK(rd[15], 1'b0)
    op(dsp_pkg::OP_MPY, 1'b0, 72'h5);
    op(dsp_pkg::OP_MSC, 1'b0, 72'h3);
    st(1'b0, -7'sd32, 1'b0, 32'h2);
    op(dsp_pkg::OP_MULT_NEGATE_OP, 1'b0, 72'h7);
    st(1'b0, -7'sd32, 1'b0, 32'hFFFF_FFF9);
    op(op_acc, 1'b0, 72'h4);
    st(1'b0, -7'sd32, 1'b0, 32'hFFFF_FFFD);
    bus(1'b1, `OFS_CORE_CONFIG, 32'h21);
    op(dsp_pkg::OP_MPY, 1'b0, 72'h5);
    st(1'b0, -7'sd32, 1'b0, 32'hA);
    $display("test multiply done");
  endtask : t_mult

  task automatic t_store;
    op(op_ld, 1'b1, 72'h00_1234_5678_9ABC_DEF0);
    st(1'b1, 7'sd0, 1'b0, 32'h1234_5678);
    st(1'b1, 7'sd4, 1'b0, 32'h0123_4567);
    st(1'b1, 7'sd0, 1'b1, 32'h1234_5679);
    st(1'b1, 7'sd0, 1'b0, 32'h1234_5678);
    op(op_ld, 1'b0, 72'h00_0000_0002_8000_0000);
    st(1'b0, 7'sd0, 1'b1, 32'h3);
    bus(1'b1, `OFS_CORE_CONFIG, 32'h23);
    st(1'b0, 7'sd0, 1'b1, 32'h2);
    op(op_ld, 1'b0, 72'h00_0000_0003_8000_0000);
    st(1'b0, 7'sd0, 1'b1, 32'h4);
    op(op_ld, 1'b0, 72'h01_0000_0000_0000_0000);
    st(1'b0, 7'sd0, 1'b0, 32'h7FFF_FFFF);
    c.word = 1'b1;
    op(op_ld, 1'b0, 72'h00_8000_0000_0000_0000);
    st(1'b0, 7'sd0, 1'b0, 32'h0000_7FFF);
    `CHK(store_out.valid, 1'b1)
    bus(1'b1, `OFS_CORE_CONFIG, 32'h01);
    op(dsp_pkg::OP_STORE, 1'b0, 72'h0);
    `CHK(store_out.data[15:0], 16'h8000)
    bus(1'b1, `OFS_CORE_CONFIG, 32'h21);
    op(op_ld, 1'b0, 72'hFF_7FFF_0000_0000_0000);
    op(dsp_pkg::OP_STORE, 1'b0, 72'h0);
    `CHK(store_out.data[15:0], 16'h8000)
    c.word = 1'b0;
    $display("test store done");
  endtask : t_store

  // Store clamp stays off here so the raw accumulator reaches the port
  task automatic t_sat;
    bus(1'b1, `OFS_CORE_CONFIG, 32'h81);
    op(op_ld, 1'b0, `MAX_163);
    op(op_add, 1'b0, 72'h1);
    st(1'b0, -7'sd8, 1'b0, 32'hFFFF_FFFF);
    op(op_ld, 1'b0, 72'h0);
    bus(1'b0, `OFS_CPU_FLAGS, 32'h0);
    `CHK(rd[15:10], 6'b001001)
    bus(1'b1, `OFS_CPU_FLAGS, 32'hF000);
    bus(1'b0, `OFS_CPU_FLAGS, 32'h0);
    `CHK(rd[15:10], 6'b000000)
    bus(1'b1, `OFS_CPU_FLAGS, 32'h3400);
    bus(1'b0, `OFS_CPU_FLAGS, 32'h0);
    `CHK(rd[15:10], 6'b001101)
    bus(1'b1, `OFS_CORE_CONFIG, 32'h91);
    op(op_ld, 1'b0, `MAX_963);
    op(op_add, 1'b0, 72'h1);
    st(1'b0, 7'sd8, 1'b0, 32'h7FFF_FFFF);
    $display("test saturation done");
  endtask : t_sat

  task automatic t_traps;
    bus(1'b1, `OFS_CORE_CONFIG, 32'h01);
    bus(1'b1, `OFS_CPU_FLAGS, 32'h0);
    bus(1'b1, `OFS_TRAP_CONTROL, 32'h0008_0000);
    op(op_ld, 1'b0, `MAX_963);
    op(op_add, 1'b0, 72'h1);
    `CHK(trap_req, 1'b1)
    st(1'b0, 7'sd8, 1'b0, 32'h8000_0000);
    bus(1'b0, `OFS_CPU_FLAGS, 32'h0);
    `CHK(rd[13], 1'b1)
    bus(1'b0, `OFS_TRAP_CONTROL, 32'h0);
    `CHK(rd[3], 1'b1)
    bus(1'b1, `OFS_TRAP_CONTROL, 32'h0010_0000);
    op(op_ld, 1'b0, 72'h00_8000_0000_0000_0000);
    `CHK(trap_req, 1'b0)
    op(op_ld, 1'b1, `MAX_163);
    op(op_add, 1'b1, 72'h1);
    `CHK(trap_req, 1'b1)
    bus(1'b0, `OFS_TRAP_CONTROL, 32'h0);
    `CHK(rd[4], 1'b1)
    bus(1'b1, `OFS_CPU_FLAGS, 32'h0);
    op(dsp_pkg::OP_INT_WRITE, 1'b1, 72'h80_0000_0000_0000_0000);
    bus(1'b0, `OFS_CPU_FLAGS, 32'h0);
    `CHK(rd[15:10], 6'b000000)
    op(op_ld, 1'b0, 72'h00_1234_5678_0000_0000);
    c.shamt = 7'sd33;
    op(dsp_pkg::OP_SHIFT_ACC, 1'b0, 72'h0);
    `CHK(trap_req, 1'b1)
    st(1'b0, 7'sd0, 1'b0, 32'h1234_5678);
    bus(1'b0, `OFS_TRAP_CONTROL, 32'h0);
    `CHK(rd[1], 1'b1)
    c.shamt = 7'sd32;
    op(dsp_pkg::OP_SHIFT_ACC, 1'b0, 72'h0);
    `CHK(trap_req, 1'b0)
    st(1'b0, -7'sd32, 1'b0, 32'h1234_5678);
    $display("test traps done");
  endtask : t_traps

  // Write-back of the other accumulator while A keeps accumulating zero
  task automatic t_wb;
    op(op_ld, 1'b1, 72'h00_1234_5678_9ABC_DEF0);
    c.wb_en = 1'b1;
    c.wb_reg = 3'h4;
    op(op_acc, 1'b0, 72'h0);
    `CHK(wb_reg_out.data, 32'h1234_5679)
    `CHK(wb_reg_out.reg_idx, 3'h4)
    bus(1'b1, `OFS_WB_POINTER, 32'h100);
    w0 = writes;
    c.wb_indirect = 1'b1;
    op(op_acc, 1'b0, 72'h0);
    `CHK(wb_mem_out.addr, 32'h100)
    `CHK(wb_mem_out.data, 32'h1234_5679)
    c.word = 1'b1;
    op(op_acc, 1'b0, 72'h0);
    bus(1'b0, `OFS_WB_POINTER, 32'h0);
    `CHK(rd, 32'h106)
    `CHK(last_data[15:0], 16'h1234)
    c.word = 1'b0;
    c.wb_use_sp = 1'b1;
    bus(1'b1, `OFS_STACK_PTR, 32'h200);
    op(op_acc, 1'b0, 72'h0);
    bus(1'b0, `OFS_STACK_PTR, 32'h0);
    `CHK(rd, 32'h204)
    `CHK(last_addr, 32'h200)
    `CHK(writes, w0 + 8'h03)
    c.wb_indirect = 1'b0;
    op(op_ld, 1'b1, `MAX_163);
    op(op_acc, 1'b0, 72'h0);
    `CHK(wb_reg_out.data, 32'h7FFF_FFFF)
    $display("test write-back done");
  endtask : t_wb

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Reset for three cycles, then run every scenario in turn
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    cmd = '0;
    c = '0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_mult();
    t_store();
    t_sat();
    t_traps();
    t_wb();
    close_out();
  end
endmodule : dsp_accumulator_datapath_tb_top
